/* pkg/sfp_pkg.sv */
// Shared constants, types and lane helpers for the serial flash link
package sfp_pkg;

  // ****************************************************************
  // Link geometry
  // ****************************************************************
  localparam int LANES = 4;
  localparam int WP_LANE = 2;
  localparam int HOLD_LANE = 3;
  localparam logic PULL_LEVEL = 1'b1;
  localparam logic [3:0] SIDE_MASK = 4'hc;
  localparam int CFG_W = 13;

  // ****************************************************************
  // Array organisation
  // ****************************************************************
  localparam int PAGE_BYTES = 256;
  localparam int ADDR_BYTES = 3;
  localparam logic [8:0] BODY_MAX = 9'(ADDR_BYTES + PAGE_BYTES);
  localparam logic [10:0] SECTOR_COUNT = 11'h200;
  localparam logic [10:0] BLOCK_SECTORS = 11'h010;
  localparam logic [10:0] SMALL_CAP = 11'h008;
  localparam logic [2:0] SMALL_CAP_BP = 3'h4;
  localparam logic [2:0] BP_NONE = 3'h0;

  // ****************************************************************
  // Timing on the system clock
  // ****************************************************************
  localparam int DIV_W = 2;
  localparam logic [DIV_W-1:0] HALF_LAST = 2'h1;
  localparam logic [3:0] CS_IDLE_MIN = 4'h8;

  typedef enum logic [1:0] {W_SINGLE, W_DUAL, W_QUAD} sfp_width_e;

  function automatic logic widthOk(input logic [1:0] w);
    widthOk = (w == W_SINGLE) || (w == W_DUAL) || (w == W_QUAD);
  endfunction

  function automatic logic [2:0] bitsOf(input sfp_width_e w);
    bitsOf = (w == W_QUAD) ? 3'h4 : (w == W_DUAL) ? 3'h2 : 3'h1;
  endfunction

  function automatic logic lastBeat(input logic [2:0] cnt,
                                    input sfp_width_e w);
    lastBeat = (w == W_QUAD) ? (cnt == 3'h1) :
               (w == W_DUAL) ? (cnt == 3'h3) : (cnt == 3'h7);
  endfunction

  // Most significant bits first on every lane setting
  function automatic logic [3:0] outSlice(input logic [7:0] b,
                                          input sfp_width_e w);
    outSlice = (w == W_QUAD) ? b[7:4] :
               (w == W_DUAL) ? {2'h0, b[7:6]} : {3'h0, b[7]};
  endfunction

  function automatic logic [7:0] shiftIn(input logic [7:0] sh,
                                         input sfp_width_e w,
                                         input logic [3:0] ln);
    shiftIn = (w == W_QUAD) ? {sh[3:0], ln} :
              (w == W_DUAL) ? {sh[5:0], ln[1:0]} : {sh[6:0], ln[0]};
  endfunction

  function automatic logic [3:0] laneMask(input sfp_width_e w);
    laneMask = (w == W_QUAD) ? 4'hf : (w == W_DUAL) ? 4'h3 : 4'h1;
  endfunction

endpackage

/* pkg/sfp_link_if.sv */
// Pin-level link between host controller and flash device
`timescale 1ns/1ps
interface sfp_link_if;
  import sfp_pkg::*;
  logic spiClk;
  logic csN;
  logic [3:0] hostOut;
  logic [3:0] hostOe;
  logic [3:0] devOut;
  logic [3:0] devOe;
  logic [3:0] lane;

  // Lanes float to the pull-up level when nobody drives
  always_comb
  begin
    for (int i = 0; i < LANES; i++)
    begin
      lane[i] = hostOe[i] ? hostOut[i] :
                devOe[i] ? devOut[i] : PULL_LEVEL;
    end
  end

  modport host(output spiClk, output csN, output hostOut,
               output hostOe, input lane);
  modport dev(input spiClk, input csN, input lane,
              output devOut, output devOe);
endinterface

/* hdl/sfp_sync.sv */
// Two-stage synchroniser with clock enable
`timescale 1ns/1ps
module sfp_sync #(parameter int WIDTH = 1) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic en,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta <= '0;
      q <= '0;
    end
    else if (en)
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

/* hdl/sfp_flash_end.sv */
// Flash device end of the serial link: lane capture, drive and pin sharing
//
// Summary of operation
// RULE1 - Single mode: input pin sampled on rising
// RULE2 - Single mode: output pin changes on falling
// RULE3 - Multi-lane: capture rising, drive falling, bidirectional
// RULE4 - Dual uses lanes 0-1, quad all four
// RULE5 - Quad and four-line need quad enable set
// RULE6 - Quad enable turns pins into lanes 2,3
// RULE7 - Four-line instruction byte in two clocks
// RULE8 - Chip select high: all lanes released
// RULE9 - Internal cycles survive chip select rising
// RULE10 - Chip select low: take bits, return data
// RULE11 - Ignore frames until chip select falls once
// RULE12 - Pause low while selected: release, ignore clock
// RULE13 - Pause released: resume where stopped
// RULE14 - Quad enable disables pause function
// RULE15 - Write-protect low blocks status writes
// RULE16 - Protect bits give sector up to array
// RULE17 - Quad enable disables write-protect function
// RULE18 - Page program takes 1 to 256 bytes
// RULE19 - 512 sectors of 4K, 256-byte pages
// RULE20 - Most significant bit first everywhere
// RULE21 - Chip select rising ends the frame
`timescale 1ns/1ps
module sfp_flash_end import sfp_pkg::*; (
  // System side
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  // Link
  sfp_link_if.dev link,
  // Configuration
  input wire logic quadEnable,
  input wire logic fourLineCommandMode,
  input wire logic statusLockMode,
  input wire logic protectComplement,
  input wire logic smallUnitSelect,
  input wire logic topBottomSelect,
  input wire logic [2:0] protectRange,
  input wire sfp_width_e bodyWidth,
  input wire logic bodyDrive,
  input wire logic [7:0] txData,
  // Received stream and status
  output logic [7:0] rxData,
  output logic rxIsInstr,
  output logic rxValid,
  output logic txTaken,
  output logic frameEnd,
  output logic armed,
  output logic statusWriteBlocked,
  output logic [9:0] protStart,
  output logic [9:0] protCount
);

  // ****************************************************************
  // Crossings
  // ****************************************************************
  logic [CFG_W-1:0] cfgQ;
  logic qeL;
  logic flL;
  logic [1:0] bwRaw;
  logic drvL;
  logic [7:0] txL;
  logic rxTgl;
  logic txTgl;
  logic csS;
  logic wpS;
  logic rxTS;
  logic txTS;

  // Settings move into the link domain only on link clock edges
  sfp_sync #(.WIDTH(CFG_W)) cfgSync (
    .clk(link.spiClk),
    .reset_n(reset_n),
    .en(1'b1),
    .d({quadEnable, fourLineCommandMode, bodyWidth, bodyDrive, txData}),
    .q(cfgQ)
  );
  assign {qeL, flL, bwRaw, drvL, txL} = cfgQ;

  sfp_sync #(.WIDTH(4)) sysSync (
    .clk(sys_clk),
    .reset_n(reset_n),
    .en(clkEn),
    .d({link.csN, link.lane[WP_LANE], rxTgl, txTgl}),
    .q({csS, wpS, rxTS, txTS})
  );

  // ****************************************************************
  // Link framing
  // ****************************************************************
  logic frameRunN;
  logic paused;
  logic phaseInstr;
  logic dropped;
  logic [2:0] beatCnt;
  logic [8:0] byteCount;
  logic [7:0] rxShift;
  logic [7:0] rxHold;
  logic rxHoldInstr;
  logic [7:0] txShift;
  logic [3:0] outReg;
  logic [3:0] oeReg;
  sfp_width_e curWidth;
  logic badWidth;
  logic active;
  logic receiving;
  logic endOfByte;
  logic driveNow;
  logic [3:0] nextSlice;

  // Frame logic clears whenever the chip is deselected; armed is static
  assign frameRunN = reset_n & ~link.csN & armed; // see RULE11 see RULE21
  assign paused = ~qeL & ~link.lane[HOLD_LANE]; // see RULE12 see RULE14
  always_comb
  begin
    curWidth = sfp_width_e'(bwRaw);
    if (phaseInstr)
    begin
      curWidth = flL ? W_QUAD : W_SINGLE; // see RULE7
    end
  end
  assign badWidth = ~widthOk(bwRaw) | (curWidth == W_QUAD & ~qeL); // see RULE5
  assign active = ~paused & ~dropped;
  assign receiving = phaseInstr | ~drvL;
  assign endOfByte = lastBeat(beatCnt, curWidth);
  assign driveNow = active & ~badWidth & ~phaseInstr & drvL;

  // ****************************************************************
  // Rising edge: capture
  // ****************************************************************
  always_ff @(posedge link.spiClk or negedge frameRunN)
  begin
    if (!frameRunN)
    begin
      phaseInstr <= 1'b1;
      dropped <= 1'b0;
      beatCnt <= 3'h0;
      byteCount <= 9'h000;
      rxShift <= 8'h00;
    end
    else if (active) // see RULE13
    begin
      if (badWidth)
      begin
        dropped <= 1'b1; // see RULE5
      end
      else
      begin
        if (receiving)
        begin
          rxShift <= shiftIn(rxShift, curWidth, link.lane); // see RULE1 see RULE3 see RULE20
        end
        if (endOfByte)
        begin
          beatCnt <= 3'h0;
          phaseInstr <= 1'b0;
          if (byteCount <= BODY_MAX)
          begin
            byteCount <= byteCount + 9'h001;
          end
        end
        else
        begin
          beatCnt <= beatCnt + 3'h1;
        end
      end
    end
  end

  // Hand-off word survives deselect so the last byte still crosses
  always_ff @(posedge link.spiClk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rxHold <= 8'h00;
      rxHoldInstr <= 1'b0;
      rxTgl <= 1'b0;
    end
    else if (frameRunN & active & ~badWidth & receiving & endOfByte
             & byteCount <= BODY_MAX) // see RULE18 see RULE10
    begin
      rxHold <= shiftIn(rxShift, curWidth, link.lane);
      rxHoldInstr <= phaseInstr;
      rxTgl <= ~rxTgl;
    end
  end

  // ****************************************************************
  // Falling edge: drive
  // ****************************************************************
  assign nextSlice = (beatCnt == 3'h0) ? outSlice(txL, curWidth)
                                       : outSlice(txShift, curWidth);

  always_ff @(negedge link.spiClk or negedge frameRunN)
  begin
    if (!frameRunN)
    begin
      txShift <= 8'h00;
      outReg <= 4'h0;
      oeReg <= 4'h0;
    end
    else if (active)
    begin
      if (driveNow)
      begin
        if (beatCnt == 3'h0)
        begin
          txShift <= txL << bitsOf(curWidth);
        end
        else
        begin
          txShift <= txShift << bitsOf(curWidth);
        end
        // Single mode answers on lane 1, wider modes from lane 0 up
        if (curWidth == W_SINGLE)
        begin
          outReg <= {2'h0, nextSlice[0], 1'b0}; // see RULE2
          oeReg <= {2'h0, 1'b1, 1'b0};
        end
        else
        begin
          outReg <= nextSlice; // see RULE3 see RULE4
          oeReg <= laneMask(curWidth); // see RULE4
        end
      end
      else
      begin
        oeReg <= 4'h0;
      end
    end
  end

  always_ff @(negedge link.spiClk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      txTgl <= 1'b0;
    end
    else if (frameRunN & driveNow & beatCnt == 3'h0)
    begin
      txTgl <= ~txTgl;
    end
  end

  assign link.devOut = outReg;
  assign link.devOe = oeReg & {LANES{~link.csN & ~paused}}; // see RULE8 see RULE12

  // ****************************************************************
  // System side
  // ****************************************************************
  logic csP;
  logic rxTP;
  logic txTP;

  function automatic logic [19:0] protRegion(input logic cmp,
                                             input logic sec,
                                             input logic tb,
                                             input logic [2:0] bp);
    logic [10:0] cnt;
    logic [10:0] start;
    cnt = 11'h000;
    if (bp != BP_NONE)
    begin
      if (sec)
      begin
        cnt = (bp >= SMALL_CAP_BP) ? SMALL_CAP : 11'h001 << (bp - 3'h1);
      end
      else
      begin
        cnt = BLOCK_SECTORS << (bp - 3'h1);
      end
    end
    if (cnt > SECTOR_COUNT)
    begin
      cnt = SECTOR_COUNT;
    end
    start = tb ? 11'h000 : SECTOR_COUNT - cnt;
    if (cmp)
    begin
      start = tb ? cnt : 11'h000;
      cnt = SECTOR_COUNT - cnt;
    end
    protRegion = {start[9:0], cnt[9:0]};
  endfunction

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      csP <= 1'b0;
      rxTP <= 1'b0;
      txTP <= 1'b0;
      armed <= 1'b0;
      rxValid <= 1'b0;
      txTaken <= 1'b0;
      frameEnd <= 1'b0;
      rxData <= 8'h00;
      rxIsInstr <= 1'b0;
    end
    else if (clkEn)
    begin
      csP <= csS;
      rxTP <= rxTS;
      txTP <= txTS;
      armed <= armed | csS; // see RULE11
      rxValid <= rxTS ^ rxTP;
      txTaken <= txTS ^ txTP;
      frameEnd <= csS & ~csP & armed; // see RULE21 see RULE9
      if (rxTS ^ rxTP)
      begin
        rxData <= rxHold;
        rxIsInstr <= rxHoldInstr;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      statusWriteBlocked <= 1'b1;
      protStart <= 10'h000;
      protCount <= 10'h000;
    end
    else if (clkEn)
    begin
      statusWriteBlocked <= ~quadEnable & statusLockMode & ~wpS; // see RULE15 see RULE17 see RULE6
      {protStart, protCount} <= protRegion(protectComplement,
                                           smallUnitSelect,
                                           topBottomSelect,
                                           protectRange); // see RULE16 see RULE19
    end
  end
endmodule

/* hdl/sfp_host_end.sv */
// Host controller end: makes the link clock and runs one frame per request
`timescale 1ns/1ps
module sfp_host_end import sfp_pkg::*; (
  // System side
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  // Link
  sfp_link_if.host link,
  // Request
  input wire logic start,
  input wire logic [7:0] instr,
  input wire logic fourLine,
  input wire sfp_width_e bodyWidth,
  input wire logic bodyRead,
  input wire logic [8:0] bodyLen,
  input wire logic [7:0] wrData,
  // Pin sharing
  input wire logic quadEnable,
  input wire logic holdReq,
  input wire logic writeProtectN,
  // Answer
  output logic busy,
  output logic refused,
  output logic wrTake,
  output logic [7:0] rdData,
  output logic rdValid,
  output logic done
);
  typedef enum {H_IDLE, H_CMD, H_BODY, H_LAST, H_GAP} sfp_host_state_e;

  sfp_host_state_e state;
  logic [3:0] laneS;
  logic [3:0] rxLanes;
  logic [DIV_W-1:0] divCnt;
  logic [3:0] gapCnt;
  logic sclk;
  logic csN;
  logic [2:0] beat;
  logic [7:0] shift;
  logic [7:0] rxShift;
  logic [8:0] remain;
  sfp_width_e width;
  sfp_width_e bodyW;
  logic rd;
  logic [3:0] dataOut;
  logic [3:0] dataOe;
  logic [3:0] sideOut;
  logic [3:0] sideOe;
  logic tick;
  logic bad;
  logic more;
  sfp_width_e cmdW;

  sfp_sync #(.WIDTH(LANES)) laneSync (
    .clk(sys_clk),
    .reset_n(reset_n),
    .en(clkEn),
    .d(link.lane),
    .q(laneS)
  );

  // ****************************************************************
  // Request check and clocking
  // ****************************************************************
  assign cmdW = fourLine ? W_QUAD : W_SINGLE;
  assign bad = ((fourLine | bodyWidth == W_QUAD) & ~quadEnable) // see RULE5
               | ~widthOk(bodyWidth)
               | (~bodyRead & bodyLen > BODY_MAX); // see RULE18
  // Clock stops while paused; restart waits until the pause pin is high
  // again, so no link edge meets a device that is still paused
  assign tick = (divCnt == HALF_LAST) & ~holdReq
                & sideOut[HOLD_LANE]; // see RULE13
  assign rxLanes = (width == W_SINGLE) ? {3'h0, laneS[1]} : laneS;
  assign more = (state == H_CMD) ? (remain != 9'h000)
                                 : (remain != 9'h001);
  assign busy = (state != H_IDLE);

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      divCnt <= '0;
    end
    else if (clkEn)
    begin
      if (state == H_IDLE | tick)
      begin
        divCnt <= '0;
      end
      else if (~holdReq)
      begin
        divCnt <= divCnt + 2'h1;
      end
    end
  end

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= H_GAP; // see RULE11
      gapCnt <= 4'h0;
      sclk <= 1'b0;
      csN <= 1'b1;
      beat <= 3'h0;
      shift <= 8'h00;
      rxShift <= 8'h00;
      remain <= 9'h000;
      width <= W_SINGLE;
      bodyW <= W_SINGLE;
      rd <= 1'b0;
      dataOut <= 4'h0;
      dataOe <= 4'h0;
      refused <= 1'b0;
      wrTake <= 1'b0;
      rdData <= 8'h00;
      rdValid <= 1'b0;
      done <= 1'b0;
    end
    else if (clkEn)
    begin
      refused <= 1'b0;
      wrTake <= 1'b0;
      rdValid <= 1'b0;
      done <= 1'b0;
      unique case (state)
        H_IDLE:
        begin
          if (start & bad)
          begin
            refused <= 1'b1;
          end
          else if (start)
          begin
            csN <= 1'b0;
            sclk <= 1'b0;
            shift <= instr << bitsOf(cmdW);
            dataOut <= outSlice(instr, cmdW); // see RULE20
            dataOe <= laneMask(cmdW); // see RULE7
            width <= cmdW;
            bodyW <= bodyWidth;
            rd <= bodyRead;
            remain <= bodyLen;
            beat <= 3'h0;
            state <= H_CMD;
          end
        end
        H_CMD, H_BODY:
        begin
          if (tick)
          begin
            sclk <= ~sclk;
          end
          // Data changes on falling edges; device samples on rising
          if (tick & sclk) // see RULE1 see RULE3
          begin
            if (state == H_BODY & rd)
            begin
              rxShift <= shiftIn(rxShift, width, rxLanes);
            end
            if (lastBeat(beat, width))
            begin
              beat <= 3'h0;
              if (state == H_BODY)
              begin
                remain <= remain - 9'h001;
              end
              if (state == H_BODY & rd)
              begin
                rdData <= shiftIn(rxShift, width, rxLanes);
                rdValid <= 1'b1;
              end
              dataOe <= 4'h0;
              if (more)
              begin
                state <= H_BODY;
                width <= bodyW;
                if (~rd)
                begin
                  shift <= wrData << bitsOf(bodyW);
                  dataOut <= outSlice(wrData, bodyW);
                  dataOe <= laneMask(bodyW); // see RULE4
                  wrTake <= 1'b1;
                end
              end
              else
              begin
                state <= H_LAST;
              end
            end
            else
            begin
              beat <= beat + 3'h1;
              dataOut <= outSlice(shift, width);
              shift <= shift << bitsOf(width);
            end
          end
        end
        H_LAST:
        begin
          if (tick)
          begin
            csN <= 1'b1; // see RULE21
            gapCnt <= 4'h0;
            state <= H_GAP;
          end
        end
        H_GAP:
        begin
          gapCnt <= gapCnt + 4'h1;
          if (gapCnt == CS_IDLE_MIN)
          begin
            state <= H_IDLE;
            done <= csN;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Shared pins: protect and pause levels only without quad enable
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sideOut <= 4'h0;
      sideOe <= 4'h0;
    end
    else if (clkEn)
    begin
      sideOut <= {~holdReq, writeProtectN, 2'h0};
      sideOe <= quadEnable ? 4'h0 : SIDE_MASK; // see RULE6
    end
  end

  assign link.spiClk = sclk;
  assign link.csN = csN;
  assign link.hostOut = (dataOut & dataOe) | (sideOut & ~dataOe);
  assign link.hostOe = dataOe | (sideOe & ~dataOe);
endmodule

/* bench/sfp_link_monitor.sv */
// Concurrent checks on the host-to-flash link pins
`timescale 1ns/1ps
module sfp_link_monitor (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Link pins
  input wire logic spiClk,
  input wire logic csN,
  input wire logic [3:0] hostOut,
  input wire logic [3:0] hostOe,
  input wire logic [3:0] devOut,
  input wire logic [3:0] devOe
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  // ****************************************************************
  // Lane ownership
  // ****************************************************************
  deselect_release_a: assert property (
    csN && $past(csN) |-> devOe == 4'h0)
    else $error("device drives a lane while deselected");
  host_release_a: assert property (
    csN |-> hostOe[1:0] == 2'h0)
    else $error("host drives data lanes between frames");
  pause_release_a: assert property (
    !csN && hostOe[3] && !hostOut[3] |-> devOe == 4'h0)
    else $error("device drives a lane while paused");
  no_contention_a: assert property (
    (hostOe & devOe & 4'h3) == 4'h0)
    else $error("both ends drive one lane");

  // ****************************************************************
  // Clock and edges
  // ****************************************************************
  clock_idle_a: assert property (
    csN |-> !spiClk)
    else $error("link clock not low while deselected");
  frame_start_a: assert property (
    $fell(csN) |-> hostOe[0] && !spiClk)
    else $error("frame opened without first bit");
  clock_pace_a: assert property (
    $changed(spiClk) |=> $stable(spiClk))
    else $error("link clock phase shorter than two cycles");
  host_setup_a: assert property (
    $rose(spiClk) |-> $stable(hostOut[2:0] & hostOe[2:0]))
    else $error("host data moved on rising edge");
  dev_launch_a: assert property (
    $changed(devOut & devOe) && devOe[1] && $past(devOe[1]) |-> !spiClk)
    else $error("device data moved while clock high");
endmodule

/* bench/serial_flash_pin_interface_tb.sv */
// Self-checking bench joining host and flash ends over the link
`timescale 1ns/1ps
module serial_flash_pin_interface_tb import sfp_pkg::*;;
  logic sys_clk, reset_n, start, fourLine, bodyRead, quadEnable, holdReq;
  logic writeProtectN, statusLockMode, protectComplement, smallUnitSelect;
  logic topBottomSelect, track, refused, wrTake, rdValid, done;
  logic rxIsInstr, rxValid, statusWriteBlocked;
  logic [2:0] protectRange;
  logic [7:0] instr, wrData, txData, rdData, rxData;
  logic [8:0] bodyLen;
  logic [9:0] protCount;
  logic [3:0] m;
  sfp_width_e bodyWidth;
  int failures, samplesChecked;
  logic [8:0] expRx[$];
  logic [7:0] expRd[$];
  logic [4:0] pTab[5] = '{5'h0a, 5'h01, 5'h1a, 5'h07, 5'h00};
  logic [9:0] pExp[5] = '{10'h002, 10'h010, 10'h1fe, 10'h200, 10'h000};

  sfp_link_if link();
  sfp_host_end sfp_host_end_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .clkEn(1'b1), .link(link), .start(start), .instr(instr),
    .fourLine(fourLine), .bodyWidth(bodyWidth), .bodyRead(bodyRead),
    .bodyLen(bodyLen), .wrData(wrData), .quadEnable(quadEnable),
    .holdReq(holdReq), .writeProtectN(writeProtectN), .busy(),
    .refused(refused), .wrTake(wrTake), .rdData(rdData),
    .rdValid(rdValid), .done(done));
  sfp_flash_end sfp_flash_end_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .clkEn(1'b1), .link(link), .quadEnable(quadEnable),
    .fourLineCommandMode(fourLine), .statusLockMode(statusLockMode),
    .protectComplement(protectComplement),
    .smallUnitSelect(smallUnitSelect), .topBottomSelect(topBottomSelect),
    .protectRange(protectRange), .bodyWidth(bodyWidth),
    .bodyDrive(bodyRead), .txData(txData), .rxData(rxData),
    .rxIsInstr(rxIsInstr), .rxValid(rxValid), .txTaken(), .frameEnd(),
    .armed(), .statusWriteBlocked(statusWriteBlocked), .protStart(),
    .protCount(protCount));
  sfp_link_monitor sfp_link_monitor_inst (.sys_clk(sys_clk),
    .reset_n(reset_n), .spiClk(link.spiClk), .csN(link.csN),
    .hostOut(link.hostOut), .hostOe(link.hostOe), .devOut(link.devOut),
    .devOe(link.devOe));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic frame(input sfp_width_e w, input logic fl, input logic rd,
                       input logic [8:0] n);
    logic [7:0] b;
    logic refE, r, d;
    int t;
    b = 8'($urandom);
    refE = ((w == W_QUAD || fl) && !quadEnable) || w == 2'h3;
    r = 1'b0;
    d = 1'b0;
    if (track && !refE) expRx.push_back({1'b1, b});
    if (track && !refE && rd) repeat (n) expRd.push_back(txData);
    @(posedge sys_clk);
    instr <= b;
    bodyWidth <= w;
    fourLine <= fl;
    bodyRead <= rd;
    bodyLen <= n;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    for (t = 0; t < 4000 && !d && !r; t++)
    begin
      #1;
      r = refused === 1'b1;
      d = done === 1'b1;
      @(posedge sys_clk);
    end
    if (t == 4000) failures++;
    check(r, refE);
  endtask

  // ****************************************************************
  // Stimulus and result watchers
  // ****************************************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial
  begin
    #(40 * 40000);
    failures++;
    summarize();
  end

  always @(posedge sys_clk)
    if (wrTake === 1'b1)
    begin
      if (track && !bodyRead) expRx.push_back({1'b0, wrData});
      wrData <= 8'($urandom);
    end

  always @(posedge sys_clk)
  begin
    m = (bodyWidth == W_QUAD) ? 4'hf : (bodyWidth == W_DUAL) ? 4'h3 : 4'h2;
    if (track && rxValid === 1'b1)
      check({rxIsInstr, rxData}, expRx.size() ? expRx.pop_front() : 9'h1ff);
    if (track && rdValid === 1'b1)
      check(rdData, expRd.size() ? expRd.pop_front() : ~rdData);
    if (track && link.devOe !== 4'h0)
      check(link.devOe & ~m, 4'h0);
  end

  initial
  begin
    {reset_n, start, fourLine, bodyRead, quadEnable, holdReq, track} = '0;
    {statusLockMode, protectComplement, smallUnitSelect} = '0;
    {topBottomSelect, protectRange, instr, wrData, txData, bodyLen} = '0;
    bodyWidth = W_SINGLE;
    writeProtectN = 1'b1;
    failures = 0;
    samplesChecked = 0;
    void'($urandom(21015));
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (12) @(posedge sys_clk);
    statusLockMode <= 1'b1;
    for (int k = 0; k < 16; k++)
    begin
      sfp_width_e w;
      logic [8:0] n;
      w = (k[1:0] == 2'h3) ? W_QUAD : sfp_width_e'(k[1:0]);
      n = 9'(1 + $urandom % 3);
      quadEnable <= k[3];
      writeProtectN <= 1'($urandom);
      topBottomSelect <= 1'($urandom);
      txData <= 8'($urandom);
      track = 1'b0;
      frame(w, k[1:0] == 2'h3, k[2], n);
      track = 1'b1;
      if (!k[3])
        fork
          begin
            repeat (30) @(posedge sys_clk);
            holdReq <= 1'b1;
            repeat (12) @(posedge sys_clk);
            holdReq <= 1'b0;
          end
        join_none
      frame(w, k[1:0] == 2'h3, k[2], n);
      check(statusWriteBlocked, !quadEnable && !writeProtectN);
    end
    frame(sfp_width_e'(2'h3), 1'b0, 1'b0, 9'h001);
    track = 1'b0;
    for (int p = 0; p < 5; p++)
    begin
      {protectComplement, smallUnitSelect, protectRange} <= pTab[p];
      frame(W_SINGLE, 1'b0, 1'b0, 9'h000);
      frame(W_SINGLE, 1'b0, 1'b0, 9'h000);
      check(protCount, pExp[p]);
    end
    check(10'(expRx.size() + expRd.size()), 10'h000);
    summarize();
  end
endmodule
